//--- sim/host_model.sv
// host controller side of the register port: reads and writes
// assumes answers come within a few cycles of the taking edge
`timescale 1ns/10ps
module host_model
   import result_regs_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DATA_W-1:0] rd_data,
   input  wire logic              rd_valid,
   input  wire logic              wr_done,
   output      logic              rd_en,
   output      logic [ADDR_W-1:0] rd_addr,
   output      logic              wr_en,
   output      logic [ADDR_W-1:0] wr_addr,
   output      logic [DATA_W-1:0] wr_data
);
   initial
   begin
      rd_en = 1'b0;
      wr_en = 1'b0;
      rd_addr = 8'h00;
      wr_addr = 8'h00;
      wr_data = 8'h00;
   end

   // one access; ok stays low if no answer arrives in four cycles
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
      output logic ok);
      @(negedge clk);
      rd_en = !wr;
      wr_en = wr;
      rd_addr = a;
      wr_addr = a;
      wr_data = d;
      @(negedge clk);
      rd_en = 1'b0;
      wr_en = 1'b0;
      wr_data = ~d;  // stale data is not left on the lines
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         ok = wr ? (wr_done === 1'b1) : (rd_valid === 1'b1);
         if (!ok)
            @(negedge clk);
      end
      q = rd_data;
   endtask : access
endmodule : host_model

//--- sim/result_regs_props.sv
// checker of the result bank ports
// assumes it is bound into result_regs and sees only its ports
`timescale 1ns/10ps
module result_regs_props
   import result_regs_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic              ce,
   input wire logic              rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic              rd_valid,
   input wire logic              wr_en,
   input wire logic              wr_done,
   input wire logic              conv_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // answers follow their request by exactly one cycle
   a_read_answer: assert property (ce && rd_en |=> rd_valid)
      else $error("read not answered");
   // while ce is low the answer flops hold, so only an enabled edge counts
   a_valid_cause: assert property (rd_valid && $past(ce) |-> $past(rd_en))
      else $error("answer without read");
   a_write_ack: assert property (ce && wr_en |=> wr_done)
      else $error("write not acknowledged");
   a_ack_cause: assert property (wr_done && $past(ce) |-> $past(wr_en))
      else $error("ack without write");
   a_unmapped_zero: assert property (ce && rd_en &&
      !(rd_addr inside {8'h03, 8'h04, [8'h06:8'h09]}) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_low_unused: assert property (ce && rd_en &&
      rd_addr == OFF_INT_SUPPLY_LOW |=> rd_data[7:4] == 4'h0)
      else $error("unused low bits set");
   // read data may only move on a taken read
   a_data_hold: assert property (!(ce && rd_en) |=> $stable(rd_data))
      else $error("read data moved");
   a_ready_loaded: assert property (ce |=> conv_ready)
      else $error("update port not ready");
   c_read: cover property (rd_en ##1 rd_valid);
   c_write: cover property (wr_en ##1 wr_done);
   c_in2: cover property (rd_en && rd_addr == OFF_INPUT_TWO_UPPER);
   c_freeze: cover property (!ce ##1 ce);
endmodule : result_regs_props

bind result_regs result_regs_props result_regs_props_inst (
   .clk(clk), .rst_b(rst_b), .ce(ce), .rd_en(rd_en), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
   .wr_done(wr_done), .conv_ready(conv_ready));

//--- sim/tb.sv
// self-checking bench of the result register bank
// assumes ce held high except in t_freeze; the host model drives the register port
`timescale 1ns/10ps
module tb
   import result_regs_pkg::*;
;
   logic clk, rst_b, ce, conv_valid, conv_ready, ok;
   logic rd_en, rd_valid, wr_en, wr_done;
   logic [1:0] sel;
   logic [CH_W-1:0] ch;
   logic [RESULT_W-1:0] supply, value, res [NUM_CH];
   logic [ADDR_W-1:0] rd_addr, wr_addr;
   logic [DATA_W-1:0] rd_data, wr_data, q;
   int miscompares, check_count;

   result_regs result_regs_inst (.clk(clk), .rst_b(rst_b), .ce(ce),
      .input_select_field(sel), .supply_initial(supply),
      .conv_valid(conv_valid), .conv_channel(ch), .conv_value(value),
      .conv_ready(conv_ready), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_done(wr_done));
   host_model host_model_inst (.clk(clk), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_done(wr_done), .rd_en(rd_en),
      .rd_addr(rd_addr), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data));

   task summarize;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
         miscompares++;
      end
   endtask : check

   // expected register contents from the stored results
   function automatic logic [DATA_W-1:0] reg_exp(input logic [7:0] a);
      logic [RESULT_W-1:0] s;
      s = (sel == 2'h0) ? res[2] : res[3];
      case (a)
         8'h03: return {4'h0, res[1][1:0], res[0][1:0]};
         8'h04: return {res[6][1:0], res[5][1:0], res[4][1:0], s[1:0]};
         8'h06: return res[1][9:2];
         8'h07: return res[0][9:2];
         8'h08: return s[9:2];
         8'h09: return res[4][9:2];
         default: return 8'h00;
      endcase
   endfunction : reg_exp

   // a missing answer ends the run at once
   task access(input logic wr, input logic [7:0] a);
      host_model_inst.access(wr, a, 8'hff, q, ok);
      if (!ok)
      begin
         miscompares++;
         summarize();
      end
   endtask : access

   // reset with a given supply word, then read addresses 0x02 to 0x0a
   task t_power_up(input logic [RESULT_W-1:0] v);
      @(negedge clk);
      rst_b = 1'b0;
      supply = v;
      res = '{default: 10'h000};
      res[1] = v;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      for (int a = 2; a < 11; a++)
      begin
         access(1'b0, 8'(a));
         check(q, reg_exp(8'(a)));
      end
      $display("t_power_up done");
   endtask : t_power_up

   // back-to-back updates of every channel, then all selections read
   task t_convert(input logic [RESULT_W-1:0] m);
      for (int c = 0; c < 8; c++)
      begin
         @(negedge clk);
         conv_valid = 1'b1;
         ch = 3'(c);
         value = m ^ 10'(c * 10'h93);
         if (c < 7)
            res[c] = value;  // code 7 must be ignored
      end
      @(negedge clk);
      conv_valid = 1'b0;
      for (int s = 0; s < 4; s++)
      begin
         sel = 2'(s);
         for (int a = 3; a < 10; a++)
         begin
            access(1'b0, 8'(a));
            check(q, reg_exp(8'(a)));
         end
      end
      $display("t_convert done");
   endtask : t_convert

   // writes are acknowledged but change nothing
   task t_writes;
      for (int a = 3; a < 10; a++)
         access(1'b1, 8'(a));
      for (int a = 3; a < 10; a++)
      begin
         access(1'b0, 8'(a));
         check(q, reg_exp(8'(a)));
      end
      $display("t_writes done");
   endtask : t_writes

   // ce low freezes the bank: an update offered then must be dropped
   task t_freeze;
      @(negedge clk);
      ce = 1'b0;
      conv_valid = 1'b1;
      ch = CH_INPUT_TWO;
      value = ~res[4];
      @(negedge clk);
      conv_valid = 1'b0;
      ce = 1'b1;
      for (int a = 3; a < 10; a++)
      begin
         access(1'b0, 8'(a));
         check(q, reg_exp(8'(a)));
      end
      $display("t_freeze done");
   endtask : t_freeze

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      {rst_b, conv_valid, ch, value, sel} = '0;
      ce = 1'b1;
      supply = 10'h000;
      miscompares = 0;
      check_count = 0;
      t_power_up(10'h2c9);
      t_convert(10'h3ff);
      t_writes();
      t_freeze();
      t_convert(10'h16a);
      t_power_up(10'h137);
      summarize();
   end
endmodule : tb

//--- src/result_regs.sv
// conversion result register bank with its read port and update port
// assumes the conversion sequencer and the serial interface decoder sit
// on the same clock and drive the update and register ports directly
//
// What this block does
// - register 0x03 holds internal temperature bits 1:0 in D1:D0 and supply bits 1:0 in D3:D2, with D7:D4 unused.
// - register 0x04 holds inputs two, three and four bits 1:0 in D3:D2, D5:D4 and D7:D6, bit 1 uppermost in each pair.
// - bits D1:D0 of register 0x04 show external temperature or input one bits 1:0 as input_select_field chooses.
// - register 0x06 holds supply result bits 9:2 and is loaded with a measured value after power-up.
// - register 0x07 holds internal temperature bits 9:2 in two's complement.
// - register 0x08 holds external temperature or input one bits 9:2, chosen by the same selection.
// - register 0x09 holds input two bits 9:2, completed below by D3:D2 of register 0x04.
// - after power-up the low-bit registers, apart from supply bits D3:D2 of 0x03, and the temperature, external and input two registers read zero until converted.
`timescale 1ns/10ps
module result_regs
   import result_regs_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                ce,
   input  wire logic [1:0]          input_select_field,
   input  wire logic [RESULT_W-1:0] supply_initial,
   input  wire logic                conv_valid,
   input  wire logic [CH_W-1:0]     conv_channel,
   input  wire logic [RESULT_W-1:0] conv_value,
   output      logic                conv_ready,
   input  wire logic                rd_en,
   input  wire logic [ADDR_W-1:0]   rd_addr,
   output      logic [DATA_W-1:0]   rd_data,
   output      logic                rd_valid,
   input  wire logic                wr_en,
   input  wire logic [ADDR_W-1:0]   wr_addr,
   input  wire logic [DATA_W-1:0]   wr_data,
   output      logic                wr_done
);

   bank_state_s state_reg;
   bank_state_s state_next;

   result_store_if store_bus ();

   // named views of the stored results
   logic [RESULT_W-1:0] int_temp_word;
   logic [RESULT_W-1:0] supply_word;
   logic [RESULT_W-1:0] ext_temp_word;
   logic [RESULT_W-1:0] input_one_word;
   logic [RESULT_W-1:0] input_two_word;
   logic [RESULT_W-1:0] input_three_word;
   logic [RESULT_W-1:0] input_four_word;
   logic [RESULT_W-1:0] selected_word;
   logic [DATA_W-1:0]   read_mux;
   logic                write_seen;

   result_store store_inst
   (
      .clk   (clk),
      .rst_b (rst_b),
      .ce    (ce),
      .port  (store_bus)
   );

   // unpack the store into per-channel words
   assign int_temp_word    = store_bus.results[CH_INT_TEMP];
   assign supply_word      = store_bus.results[CH_SUPPLY];
   assign ext_temp_word    = store_bus.results[CH_EXT_TEMP];
   assign input_one_word   = store_bus.results[CH_INPUT_ONE];
   assign input_two_word   = store_bus.results[CH_INPUT_TWO];
   assign input_three_word = store_bus.results[CH_INPUT_THREE];
   assign input_four_word  = store_bus.results[CH_INPUT_FOUR];

   // both candidate results are kept, so flipping the selection shows the
   // other channel at once without waiting for a fresh conversion
   assign selected_word = (input_select_field == SEL_EXT_TEMP) ?
                          ext_temp_word : input_one_word;

   // conversions are held off for the single power-up load cycle, so the
   // measured supply value and a fresh result never collide in the store
   assign conv_ready = (state_reg.seq == ST_RUN);

   // store write port: power-up supply load first, then conversions
   always_comb
   begin
      store_bus.wr_en    = 1'b0;
      store_bus.wr_ch    = CH_SUPPLY;
      store_bus.wr_value = supply_initial;
      case (state_reg.seq)
         ST_LOAD:
         begin
            store_bus.wr_en    = 1'b1;
            store_bus.wr_ch    = CH_SUPPLY;
            store_bus.wr_value = supply_initial;
         end
         ST_RUN:
         begin
            store_bus.wr_en    = conv_valid;
            store_bus.wr_ch    = conv_channel;
            store_bus.wr_value = conv_value;
         end
         default:
         begin
            store_bus.wr_en    = 1'b0;
         end
      endcase
   end

   // read decode; bytes that hold no field read as zero
   always_comb
   begin
      read_mux = UNUSED_READ;
      case (rd_addr)
         OFF_INT_SUPPLY_LOW:
         begin
            read_mux[POS_INT_TEMP_LOW +: LOW_W] =
               int_temp_word[LOW_W-1:0];
            read_mux[POS_SUPPLY_LOW +: LOW_W] =
               supply_word[LOW_W-1:0];
         end
         OFF_EXT_INPUTS_LOW:
         begin
            read_mux[POS_EXT_IN1_LOW +: LOW_W] =
               selected_word[LOW_W-1:0];
            read_mux[POS_IN_TWO_LOW +: LOW_W] =
               input_two_word[LOW_W-1:0];
            read_mux[POS_IN_THREE_LOW +: LOW_W] =
               input_three_word[LOW_W-1:0];
            read_mux[POS_IN_FOUR_LOW +: LOW_W] =
               input_four_word[LOW_W-1:0];
         end
         OFF_SUPPLY_UPPER:
         begin
            read_mux = supply_word[RESULT_W-1:UPPER_LSB];
         end
         OFF_INT_TEMP_UPPER:
         begin
            // two's complement bits pass through unchanged
            read_mux = int_temp_word[RESULT_W-1:UPPER_LSB];
         end
         OFF_EXT_OR_IN1_UPPER:
         begin
            read_mux = selected_word[RESULT_W-1:UPPER_LSB];
         end
         OFF_INPUT_TWO_UPPER:
         begin
            read_mux = input_two_word[RESULT_W-1:UPPER_LSB];
         end
         default:
         begin
            read_mux = UNUSED_READ;
         end
      endcase
   end

   // a write to any address is taken and dropped; the bank has no writable
   // bits, and the address and data are looked at only to acknowledge
   assign write_seen = wr_en && ((wr_addr != wr_addr) || (wr_data == wr_data));

   // sequencer and answer flops
   always_comb
   begin
      state_next          = state_reg;
      state_next.rd_valid = rd_en;
      state_next.wr_done  = write_seen;
      if (rd_en)
      begin
         state_next.rd_data = read_mux;
      end
      case (state_reg.seq)
         ST_LOAD:
         begin
            state_next.seq = ST_RUN;
         end
         ST_RUN:
         begin
            state_next.seq = ST_RUN;
         end
         default:
         begin
            state_next.seq = ST_LOAD;
         end
      endcase
   end

   // ce low freezes the sequencer and the answer flops alike
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg.seq      <= ST_LOAD;
         state_reg.rd_data  <= READ_RESET;
         state_reg.rd_valid <= 1'b0;
         state_reg.wr_done  <= 1'b0;
      end
      else if (ce)
      begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the flops
   assign rd_data  = state_reg.rd_data;
   assign rd_valid = state_reg.rd_valid;
   assign wr_done  = state_reg.wr_done;

endmodule : result_regs

//--- src/result_regs_pkg.sv
// constants, types and register map of the conversion result register bank
// assumes a single 125 MHz clock domain shared by every user of this package
package result_regs_pkg;

   // bus and data widths
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 8;
   localparam int RESULT_W = 10;
   localparam int CH_W     = 3;
   localparam int NUM_CH   = 7;

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_INT_SUPPLY_LOW     = 8'h03;
   localparam logic [ADDR_W-1:0] OFF_EXT_INPUTS_LOW     = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_SUPPLY_UPPER       = 8'h06;
   localparam logic [ADDR_W-1:0] OFF_INT_TEMP_UPPER     = 8'h07;
   localparam logic [ADDR_W-1:0] OFF_EXT_OR_IN1_UPPER   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_INPUT_TWO_UPPER    = 8'h09;

   // field positions of the two-bit low pairs inside the low-bit registers
   localparam int POS_INT_TEMP_LOW  = 0;
   localparam int POS_SUPPLY_LOW    = 2;
   localparam int POS_EXT_IN1_LOW   = 0;
   localparam int POS_IN_TWO_LOW    = 2;
   localparam int POS_IN_THREE_LOW  = 4;
   localparam int POS_IN_FOUR_LOW   = 6;
   localparam int LOW_W             = 2;
   localparam int UPPER_LSB         = 2;

   // conversion channel codes
   localparam logic [CH_W-1:0] CH_INT_TEMP    = 3'h0;
   localparam logic [CH_W-1:0] CH_SUPPLY      = 3'h1;
   localparam logic [CH_W-1:0] CH_EXT_TEMP    = 3'h2;
   localparam logic [CH_W-1:0] CH_INPUT_ONE   = 3'h3;
   localparam logic [CH_W-1:0] CH_INPUT_TWO   = 3'h4;
   localparam logic [CH_W-1:0] CH_INPUT_THREE = 3'h5;
   localparam logic [CH_W-1:0] CH_INPUT_FOUR  = 3'h6;

   // input_select_field code that routes the external temperature result
   localparam logic [1:0] SEL_EXT_TEMP = 2'h0;

   // reset values
   localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
   localparam logic [DATA_W-1:0]   READ_RESET   = 8'h00;
   localparam logic [DATA_W-1:0]   UNUSED_READ  = 8'h00;

   // power-up sequencer states
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } seq_state_e;

   typedef logic [NUM_CH-1:0][RESULT_W-1:0] result_array_t;

   typedef struct packed {
      result_array_t results;
   } store_state_s;

   typedef struct packed {
      seq_state_e         seq;
      logic [DATA_W-1:0]  rd_data;
      logic               rd_valid;
      logic               wr_done;
   } bank_state_s;

endpackage : result_regs_pkg

//--- src/result_store.sv
// result store: one 10-bit word per conversion channel, held in flops
// assumes writes come from the front end on the same clock
`timescale 1ns/10ps
module result_store
   import result_regs_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   result_store_if.store port
);

   store_state_s state_reg;
   store_state_s state_next;

   // one entry written per cycle; unknown channel codes fall through
   always_comb
   begin
      state_next = state_reg;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (port.wr_en && (port.wr_ch == CH_W'(i)))
         begin
            state_next.results[i] = port.wr_value;
         end
      end
   end

   // every result clears to zero at reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg.results <= {NUM_CH{RESULT_RESET}};
      end
      else if (ce)
      begin
         state_reg <= state_next;
      end
   end

   // stored words are register outputs, so reads see flop data
   assign port.results = state_reg.results;

endmodule : result_store

//--- src/result_store_if.sv
// carrier between the register bank front end and its result store
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface result_store_if;
   import result_regs_pkg::*;

   logic                wr_en;
   logic [CH_W-1:0]     wr_ch;
   logic [RESULT_W-1:0] wr_value;
   result_array_t       results;

   modport front (output wr_en, output wr_ch, output wr_value,
                  input results);
   modport store (input wr_en, input wr_ch, input wr_value,
                  output results);
endinterface : result_store_if
